// file: src/pid_pkg.sv
// Package of constants and types for the general pin input debouncer
`default_nettype none

package pid_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned PID_NUM_PINS = 16;       // General pins
    localparam int unsigned PID_SEL_W    = 2;        // Selector width per pin
    localparam int unsigned PID_CNT_W    = 8;        // Period count width
    localparam int unsigned PID_ADDR_W   = 12;       // APB address width

    // ------------------------------------------------------------
    // Register indices and byte addresses (index times four)
    // ------------------------------------------------------------
    localparam logic [9:0] PID_IDX_TEN_MS = 10'h06c;   // Ten-millisecond count
    localparam logic [9:0] PID_IDX_ONE_MS = 10'h06d;   // Millisecond count
    localparam logic [9:0] PID_IDX_ONE_US = 10'h06e;   // Microsecond count
    localparam logic [9:0] PID_IDX_STATUS = 10'h06f;   // Pending status
    localparam logic [9:0] PID_IDX_SELECT = 10'h070;   // Per-pin selectors
    localparam logic [11:0] PID_ADDR_TEN_MS = {PID_IDX_TEN_MS, 2'h0};
    localparam logic [11:0] PID_ADDR_ONE_MS = {PID_IDX_ONE_MS, 2'h0};
    localparam logic [11:0] PID_ADDR_ONE_US = {PID_IDX_ONE_US, 2'h0};
    localparam logic [11:0] PID_ADDR_STATUS = {PID_IDX_STATUS, 2'h0};
    localparam logic [11:0] PID_ADDR_SELECT = {PID_IDX_SELECT, 2'h0};

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0]  PID_RST_PERIOD  = 8'h0a;        // All three counts
    localparam logic [31:0] PID_RST_SELECT  = 32'h00000000; // All pins off
    localparam int unsigned PID_STS_PENDING = 0;            // Pending bit

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned PID_CLK_PERIOD_NS = 50;     // 20 MHz clock
    localparam int unsigned PID_US_NS         = 1000;   // One microsecond
    localparam int unsigned PID_MS_US         = 1000;   // One millisecond
    localparam int unsigned PID_TEN_MS_MS     = 10;     // Ten milliseconds
    localparam int unsigned PID_CYC_PER_US    = PID_US_NS / PID_CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PID_SEL_OFF    = 2'b00,    // Pass through
        PID_SEL_US     = 2'b01,    // Microsecond counter
        PID_SEL_MS     = 2'b10,    // Millisecond counter
        PID_SEL_TEN_MS = 2'b11     // Ten-millisecond counter
    } pid_sel_type;

    typedef struct packed {
        logic [31:0] select;       // Per-pin selectors
        logic [7:0]  ten_ms;       // Ten-millisecond period count
        logic [7:0]  one_ms;       // Millisecond period count
        logic [7:0]  one_us;       // Microsecond period count
    } pid_cfg_type;

    typedef struct packed {
        logic us;                  // Microsecond tick
        logic ms;                  // Millisecond tick
        logic ten_ms;              // Ten-millisecond tick
    } pid_tick_type;

endpackage : pid_pkg

`default_nettype wire

// file: src/pid_pin_cell.sv
// One pin's debounce filter with its own period counter
`default_nettype none

module pid_pin_cell
    import pid_pkg::*;
(
    input  wire logic                 CLK,
    input  wire logic                 RST,
    input  wire logic                 raw,
    input  wire logic [1:0]           sel,
    input  wire pid_tick_type         tick,
    input  wire pid_cfg_type          cfg,
    output logic                      level,
    output logic                      busy
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        PID_ST_STABLE = 1'b0,       // Output equals input
        PID_ST_SETTLE = 1'b1        // Waiting for stability
    } pid_cell_state_type;

    pid_cell_state_type  state_ff, nxt_state;   // Filter state
    logic [7:0]          cnt_ff,   nxt_cnt;     // Ticks seen while settling
    logic                level_ff, nxt_level;   // Debounced level
    logic                last_ff,  nxt_last;    // Previous raw sample
    logic                sel_tick;              // Chosen tick
    logic [7:0]          sel_period;            // Chosen period count
    logic [8:0]          cnt_inc;               // Counter plus one

    // Pick tick and period by selector
    always_comb begin
        sel_tick   = 1'b0;
        sel_period = 8'h00;
        case (pid_sel_type'(sel))
            PID_SEL_US: begin
                sel_tick   = tick.us;
                sel_period = cfg.one_us;
            end
            PID_SEL_MS: begin
                sel_tick   = tick.ms;
                sel_period = cfg.one_ms;
            end
            PID_SEL_TEN_MS: begin
                sel_tick   = tick.ten_ms;
                sel_period = cfg.ten_ms;
            end
            default: begin
                sel_tick   = 1'b0;
                sel_period = 8'h00;
            end
        endcase
    end

    // Next-state logic of the filter
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_level = level_ff;
        nxt_last  = raw;
        cnt_inc   = {1'b0, cnt_ff} + 9'h001;
        if (pid_sel_type'(sel) == PID_SEL_OFF) begin
            // No filtering: follow the input at once
            nxt_level = raw;
            nxt_state = PID_ST_STABLE;
            nxt_cnt   = 8'h00;
        end else if (raw != last_ff) begin
            // Any edge restarts the period
            nxt_cnt   = 8'h00;
            nxt_state = (raw != level_ff) ? PID_ST_SETTLE : PID_ST_STABLE;
        end else if (state_ff == PID_ST_SETTLE) begin
            // First tick may be partial: length is count or count-1
            if (sel_tick) begin
                if (cnt_inc >= {1'b0, sel_period}) begin
                    nxt_level = raw;
                    nxt_state = PID_ST_STABLE;
                    nxt_cnt   = 8'h00;
                end else begin
                    nxt_cnt = cnt_inc[7:0];
                end
            end
        end
    end

    // Register the filter
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_ff <= PID_ST_STABLE;
            cnt_ff   <= 8'h00;
            level_ff <= 1'b0;
            last_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            level_ff <= nxt_level;
            last_ff  <= nxt_last;
        end
    end

    assign level = level_ff;
    assign busy  = (state_ff == PID_ST_SETTLE);

endmodule : pid_pin_cell

`default_nettype wire

// file: src/pid_debouncer_top.sv
// Top of the general pin input debouncer with its APB register file
//
// Notes on behaviour
// - Two-bit selector per pin picks counter.
// - Changes inside the period are suppressed.
// - Ten-millisecond count, eight bits, resets 0Ah.
// - Millisecond count, eight bits, resets 0Ah.
// - Microsecond count, eight bits, resets 0Ah.
// - Effective length is count or count-1.
// - Status bit zero shows debounce pending.
// - Selectors read/write, reset to disabled.
//
// The implementer's own choice: register access over APB.
`default_nettype none

module pid_debouncer_top
    import pid_pkg::*;
#(
    parameter int unsigned CYC_PER_US   = PID_CYC_PER_US,  // Clock cycles per microsecond
    parameter int unsigned US_PER_MS    = PID_MS_US,       // Microseconds per millisecond
    parameter int unsigned MS_PER_TEN   = PID_TEN_MS_MS    // Milliseconds per ten
) (
    input  wire logic                  CLK,
    input  wire logic                  RST,
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [11:0]           PADDR,
    input  wire logic [31:0]           PWDATA,
    input  wire logic [3:0]            PSTRB,
    output logic      [31:0]           PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    input  wire logic [15:0]           GENERAL_PIN_IN,
    output logic      [15:0]           GENERAL_PIN_LEVEL,
    output logic                       DEBOUNCE_PENDING
);

    // ------------------------------------------------------------
    // Derived widths
    // ------------------------------------------------------------
    localparam int unsigned PRE_W = (CYC_PER_US > 1) ? $clog2(CYC_PER_US) : 1;
    localparam int unsigned MS_W  = (US_PER_MS  > 1) ? $clog2(US_PER_MS)  : 1;
    localparam int unsigned TEN_W = (MS_PER_TEN > 1) ? $clog2(MS_PER_TEN) : 1;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_US - 1);  // Prescaler wrap
    localparam logic [MS_W-1:0]  MS_LAST  = MS_W'(US_PER_MS - 1);    // Millisecond wrap
    localparam logic [TEN_W-1:0] TEN_LAST = TEN_W'(MS_PER_TEN - 1);  // Ten wrap

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    logic [15:0] sync_a_ff;         // First stage, read only by second
    logic [15:0] sync_b_ff;         // Second stage, safe to use

    // Two flip-flops on every pin
    always_ff @(posedge CLK) begin
        if (RST) begin
            sync_a_ff <= 16'h0000;
            sync_b_ff <= 16'h0000;
        end else begin
            sync_a_ff <= GENERAL_PIN_IN;
            sync_b_ff <= sync_a_ff;
        end
    end

    // ------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------
    logic [PRE_W-1:0] pre_ff,  nxt_pre;     // Cycles within microsecond
    logic [MS_W-1:0]  ms_ff,   nxt_ms;      // Microseconds within millisecond
    logic [TEN_W-1:0] ten_ff,  nxt_ten;     // Milliseconds within ten
    pid_tick_type     tick_ff, nxt_tick;    // One-cycle tick pulses

    // Cascaded dividers from the device clock
    always_comb begin
        nxt_pre  = pre_ff;
        nxt_ms   = ms_ff;
        nxt_ten  = ten_ff;
        nxt_tick = '0;
        if (pre_ff == PRE_LAST) begin
            nxt_pre     = '0;
            nxt_tick.us = 1'b1;
            if (ms_ff == MS_LAST) begin
                nxt_ms      = '0;
                nxt_tick.ms = 1'b1;
                if (ten_ff == TEN_LAST) begin
                    nxt_ten         = '0;
                    nxt_tick.ten_ms = 1'b1;
                end else begin
                    nxt_ten = ten_ff + TEN_W'(1);
                end
            end else begin
                nxt_ms = ms_ff + MS_W'(1);
            end
        end else begin
            nxt_pre = pre_ff + PRE_W'(1);
        end
    end

    // Register the timebase
    always_ff @(posedge CLK) begin
        if (RST) begin
            pre_ff  <= '0;
            ms_ff   <= '0;
            ten_ff  <= '0;
            tick_ff <= '0;
        end else begin
            pre_ff  <= nxt_pre;
            ms_ff   <= nxt_ms;
            ten_ff  <= nxt_ten;
            tick_ff <= nxt_tick;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    pid_cfg_type  cfg_ff, nxt_cfg;          // Software settings
    logic [15:0]  cell_level;               // Debounced levels
    logic [15:0]  cell_busy;                // Per-pin settling flags
    logic         pending_ff, nxt_pending;  // Any pin settling
    logic [15:0]  level_ff, nxt_levels;     // Output copy of levels
    logic         wr_take;                  // Write completes this edge

    assign wr_take = PSEL & PENABLE & PREADY & PWRITE;

    // Writes land at the completing edge, lane by lane
    always_comb begin
        nxt_cfg = cfg_ff;
        if (wr_take && (PADDR[1:0] == 2'h0)) begin
            if (PADDR == PID_ADDR_TEN_MS) begin
                if (PSTRB[0]) begin
                    nxt_cfg.ten_ms = PWDATA[7:0];
                end
            end else if (PADDR == PID_ADDR_ONE_MS) begin
                if (PSTRB[0]) begin
                    nxt_cfg.one_ms = PWDATA[7:0];
                end
            end else if (PADDR == PID_ADDR_ONE_US) begin
                if (PSTRB[0]) begin
                    nxt_cfg.one_us = PWDATA[7:0];
                end
            end else if (PADDR == PID_ADDR_SELECT) begin
                for (int b = 0; b < 4; b++) begin
                    if (PSTRB[b]) begin
                        nxt_cfg.select[b*8 +: 8] = PWDATA[b*8 +: 8];
                    end
                end
            end
        end
    end

    // Status and level mirrors
    always_comb begin
        nxt_pending = |cell_busy;
        nxt_levels  = cell_level;
    end

    // Register settings and mirrors
    always_ff @(posedge CLK) begin
        if (RST) begin
            cfg_ff.select <= PID_RST_SELECT;
            cfg_ff.ten_ms <= PID_RST_PERIOD;
            cfg_ff.one_ms <= PID_RST_PERIOD;
            cfg_ff.one_us <= PID_RST_PERIOD;
            pending_ff    <= 1'b0;
            level_ff      <= 16'h0000;
        end else begin
            cfg_ff     <= nxt_cfg;
            pending_ff <= nxt_pending;
            level_ff   <= nxt_levels;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic        pready_ff,  nxt_pready;    // Access ready, one wait state
    logic        pslverr_ff, nxt_pslverr;   // Error on unmapped address
    logic [31:0] prdata_ff,  nxt_prdata;    // Read data
    logic        mapped;                    // Address hits a register

    // Answer in the second access cycle
    always_comb begin
        nxt_pready  = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata  = 32'h00000000;
        mapped      = 1'b0;
        if (PADDR[1:0] == 2'h0) begin
            if (PADDR == PID_ADDR_TEN_MS) begin
                mapped     = 1'b1;
                nxt_prdata = {24'h000000, cfg_ff.ten_ms};
            end else if (PADDR == PID_ADDR_ONE_MS) begin
                mapped     = 1'b1;
                nxt_prdata = {24'h000000, cfg_ff.one_ms};
            end else if (PADDR == PID_ADDR_ONE_US) begin
                mapped     = 1'b1;
                nxt_prdata = {24'h000000, cfg_ff.one_us};
            end else if (PADDR == PID_ADDR_STATUS) begin
                // Upper status bits read as zero
                mapped     = 1'b1;
                nxt_prdata[PID_STS_PENDING] = pending_ff;
            end else if (PADDR == PID_ADDR_SELECT) begin
                mapped     = 1'b1;
                nxt_prdata = cfg_ff.select;
            end
        end
        if (PSEL && PENABLE && !pready_ff) begin
            nxt_pready  = 1'b1;
            nxt_pslverr = !mapped;
            if (PWRITE || !mapped) begin
                nxt_prdata = 32'h00000000;
            end
        end else begin
            nxt_prdata = 32'h00000000;
        end
    end

    // Register the bus answer
    always_ff @(posedge CLK) begin
        if (RST) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
        end
    end

    // ------------------------------------------------------------
    // Pin filters
    // ------------------------------------------------------------
    // One filter per pin; all share the three counts and ticks
    for (genvar n = 0; n < PID_NUM_PINS; n++) begin : g_pin
        pid_pin_cell u_cell (
            .CLK   (CLK),
            .RST   (RST),
            .raw   (sync_b_ff[n]),
            .sel   (cfg_ff.select[2*n +: 2]),
            .tick  (tick_ff),
            .cfg   (cfg_ff),
            .level (cell_level[n]),
            .busy  (cell_busy[n])
        );
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign PRDATA            = prdata_ff;
    assign PREADY            = pready_ff;
    assign PSLVERR           = pslverr_ff;
    assign GENERAL_PIN_LEVEL = level_ff;
    assign DEBOUNCE_PENDING  = pending_ff;

endmodule : pid_debouncer_top

`default_nettype wire

// file: test/pid_debouncer_asserts.sv
// Checker for the general pin debouncer ports
`default_nettype none

module pid_debouncer_asserts
    import pid_pkg::*;
#(
    parameter int unsigned CYC_PER_US = 2,  // Cycles per microsecond
    parameter int unsigned US_PER_MS  = 4,  // Microseconds per millisecond
    parameter int unsigned MS_PER_TEN = 2   // Milliseconds per ten
) (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [15:0] GENERAL_PIN_IN,
    input wire logic [15:0] GENERAL_PIN_LEVEL,
    input wire logic        DEBOUNCE_PENDING
);
    // ----------------------------------------
    // Address decode helpers
    // ----------------------------------------
    logic bad_addr;  // Unmapped or misaligned
    logic cnt_addr;  // One of the count registers
    assign bad_addr = !(PADDR inside {PID_ADDR_TEN_MS, PID_ADDR_ONE_MS, PID_ADDR_ONE_US,
                                      PID_ADDR_STATUS, PID_ADDR_SELECT});
    assign cnt_addr = PADDR inside {PID_ADDR_TEN_MS, PID_ADDR_ONE_MS, PID_ADDR_ONE_US};

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // ----------------------------------------
    // Bus timing
    // ----------------------------------------
    property p_one_wait;
        PSEL && !PENABLE |=> !PREADY ##1 PREADY;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("ready not after one wait");
    property p_ready_pulse;
        PREADY |=> !PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_idle_quiet;
        !PREADY |-> PRDATA == 32'h0 && !PSLVERR;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("read bus not quiet");
    property p_err_cause;
        PREADY |-> PSLVERR == bad_addr;
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("error flag wrong");

    // ----------------------------------------
    // Register widths
    // ----------------------------------------
    property p_cnt_width;
        PREADY && !PWRITE && cnt_addr |-> PRDATA[31:8] == 24'h0;
    endproperty
    a_cnt_width: assert property (p_cnt_width) else $error("count wider than a byte");
    property p_sts_width;
        PREADY && !PWRITE && PADDR == PID_ADDR_STATUS |-> PRDATA[31:1] == 31'h0;
    endproperty
    a_sts_width: assert property (p_sts_width) else $error("status upper bits set");

    // ----------------------------------------
    // Reset and pin behaviour
    // ----------------------------------------
    property p_reset_out;
        $fell(RST) |-> !PREADY && !PSLVERR && PRDATA == 32'h0 && GENERAL_PIN_LEVEL == 16'h0 && !DEBOUNCE_PENDING;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
    property p_level_cause;
        ((GENERAL_PIN_LEVEL ^ $past(GENERAL_PIN_LEVEL)) & (GENERAL_PIN_LEVEL ^ $past(GENERAL_PIN_IN, 4))) == 16'h0;
    endproperty
    a_level_cause: assert property (p_level_cause) else $error("level moved to a stale value");
    property p_settled;
        ($stable(GENERAL_PIN_IN) && !DEBOUNCE_PENDING) [*8] |-> GENERAL_PIN_LEVEL == GENERAL_PIN_IN;
    endproperty
    a_settled: assert property (p_settled) else $error("level stuck while idle");

endmodule : pid_debouncer_asserts

bind pid_debouncer_top pid_debouncer_asserts #(
    .CYC_PER_US(CYC_PER_US),
    .US_PER_MS (US_PER_MS),
    .MS_PER_TEN(MS_PER_TEN)
) u_chk (.*);

`default_nettype wire

// file: test/pid_pin_source.sv
// Model of the outside circuitry driving the general pins
`default_nettype none

module pid_pin_source
(
    input  wire logic        CLK,   // Device clock
    input  wire logic [15:0] want,  // Levels asked by the bench
    output var  logic [15:0] pins   // Levels on the board
);
    timeunit 1ns;
    timeprecision 1ns;
    // Board levels move just after an edge, never mid-cycle
    initial pins = 16'h0;
    always @(posedge CLK) begin
        pins <= want;
    end
endmodule : pid_pin_source

`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the general pin debouncer
`default_nettype none

module tb_top
    import pid_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [11:0] addr;   // Byte address
        logic [3:0]  strb;   // Write lanes
        logic [31:0] wdata;  // Written word
        logic [31:0] rdata;  // Word read back
        logic        err;    // Error expected
    } pid_row_type;

    logic        clk, rst, psel, penable, pwrite, pslverr, pready, pending;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [15:0] pin_req, pin_in, pin_level;
    int          failures, samples_checked;
    int          per [3] = '{2, 8, 16};   // Tick spacing per base in cycles
    pid_row_type rows [9] = '{
        '{PID_ADDR_ONE_US, 4'hf, 32'hffffff05, 32'h00000005, 1'b0},
        '{PID_ADDR_ONE_MS, 4'hf, 32'h00000003, 32'h00000003, 1'b0},
        '{PID_ADDR_TEN_MS, 4'hf, 32'h00000002, 32'h00000002, 1'b0},
        '{PID_ADDR_TEN_MS, 4'he, 32'h00000077, 32'h00000002, 1'b0},
        '{PID_ADDR_STATUS, 4'hf, 32'hffffffff, 32'h00000000, 1'b0},
        '{PID_ADDR_SELECT, 4'hf, 32'hdeadbeef, 32'hdeadbeef, 1'b0},
        '{PID_ADDR_SELECT, 4'h5, 32'h00000000, 32'hde00be00, 1'b0},
        '{12'h1c4, 4'hf, 32'h00000001, 32'h00000000, 1'b1},
        '{12'h1b5, 4'hf, 32'h00000001, 32'h00000000, 1'b1}};

    pid_pin_source u_src (.CLK(clk), .want(pin_req), .pins(pin_in));
    pid_debouncer_top #(.CYC_PER_US(2), .US_PER_MS(4), .MS_PER_TEN(2)) dut (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .GENERAL_PIN_IN(pin_in), .GENERAL_PIN_LEVEL(pin_level),
        .DEBOUNCE_PENDING(pending));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    // One APB transfer; waits for ready, releases after that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // A slave that never answers counts as a mismatch
        if (pready !== 1'b1) begin
            failures++;
        end
        // Answer taken and request released at the edge that sees ready
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic drive(input logic [15:0] v);
        @(posedge clk);
        pin_req <= v;
    endtask : drive

    // Wait, then compare levels and the pending flag
    task automatic wait_chk(input int n, input logic [15:0] lv, input logic pend);
        repeat (n) @(posedge clk);
        @(negedge clk);
        chk_word({16'h0, pin_level}, {16'h0, lv});
        chk_word({31'h0, pending}, {31'h0, pend});
    endtask : wait_chk

    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        wrap_up();
    end

    initial begin : main
        logic [31:0] rd;
        logic        er;
        logic [15:0] lv, m;
        {rst, psel, penable, pwrite, paddr, pwdata, pstrb, pin_req} = {1'b1, 67'h0};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // Register table: write, then read back
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wdata, rows[i].strb, rd, er);
            chk_word({31'h0, er}, {31'h0, rows[i].err});
            apb(1'b0, rows[i].addr, 32'h0, 4'h0, rd, er);
            chk_word(rd, rows[i].rdata);
            chk_word({31'h0, er}, {31'h0, rows[i].err});
        end
        // Mid-run reset restores every register
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, PID_ADDR_TEN_MS + 12'(4 * i), 32'h0, 4'h0, rd, er);
            chk_word(rd, i < 3 ? {24'h0, PID_RST_PERIOD} : PID_RST_SELECT);
        end
        // Selector 00 passes pins straight through
        lv = 16'ha5a5;
        drive(lv);
        wait_chk(6, lv, 1'b0);
        // Counts of four; pins 1 and 4 share the microsecond base
        apb(1'b1, PID_ADDR_TEN_MS, 32'h4, 4'hf, rd, er);
        apb(1'b1, PID_ADDR_ONE_MS, 32'h4, 4'hf, rd, er);
        apb(1'b1, PID_ADDR_ONE_US, 32'h4, 4'hf, rd, er);
        apb(1'b1, PID_ADDR_SELECT, 32'h1e4, 4'hf, rd, er);
        for (int c = 0; c < 3; c++) begin
            m = (c == 0) ? 16'h0012 : 16'h0002 << c;
            drive(lv ^ m);
            wait_chk(2 * per[c] + 4, lv, 1'b1);
            lv ^= m;
            wait_chk(2 * per[c] + 6, lv, 1'b0);
        end
        // Short pulse is swallowed
        drive(lv ^ 16'h0002);
        repeat (2) @(posedge clk);
        drive(lv);
        wait_chk(20, lv, 1'b0);
        // Bounce restarts the ten-millisecond count
        drive(lv ^ 16'h0008);
        repeat (30) @(posedge clk);
        drive(lv);
        drive(lv ^ 16'h0008);
        wait_chk(36, lv, 1'b1);
        lv ^= 16'h0008;
        wait_chk(40, lv, 1'b0);
        // Status register tracks settling
        drive(lv ^ 16'h0004);
        // Pending reaches the status bit four edges after the board pin moves
        repeat (4) @(posedge clk);
        apb(1'b0, PID_ADDR_STATUS, 32'h0, 4'h0, rd, er);
        chk_word(rd, 32'h1);
        repeat (50) @(posedge clk);
        apb(1'b0, PID_ADDR_STATUS, 32'h0, 4'h0, rd, er);
        chk_word(rd, 32'h0);
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
